/* File: hw/lios_sync.v */
`timescale 1ns/1ps
module lios_sync #(
   parameter W = 4
) (
   input  wire         mclk,
   input  wire         rstn,
   input  wire         ce,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end else if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule // lios_sync

/* File: hw/lios_timer.v */
`timescale 1ns/1ps
module lios_timer #(
   parameter W = 16
) (
   input  wire         mclk,
   input  wire         rstn,
   input  wire         ce,
   input  wire         tick,
   input  wire         start,
   input  wire         stop,
   input  wire [W-1:0] len,
   output wire         busy,
   output wire         done
);
   reg [W-1:0] cnt_r;
   reg         busy_r;
   reg         done_r;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= {W{1'b0}};
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce) begin
         done_r <= 1'b0;
         if (stop) begin
            busy_r <= 1'b0;
         end else if (start) begin
            cnt_r  <= len;
            busy_r <= 1'b1;
         end else if (busy_r && tick) begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
   assign busy = busy_r;
   assign done = done_r;
endmodule // lios_timer

/* File: hw/lios_top.v */
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lios_regs.vh"
module lios_top #(
   parameter SUPPLY_T = `LIOS_MS_TICKS(`LIOS_SUPPLY_MS),
   parameter PREP_T   = `LIOS_MS_TICKS(`LIOS_PREP_MS),
   parameter HOLD_T   = `LIOS_MS_TICKS(`LIOS_HOLDOFF_MS),
   parameter TICK_C   = `LIOS_TICK_CYC,
   parameter EW       = 16
) (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        ce,
   input  wire        haddr_sel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        ctrl_select,
   input  wire        laser_start,
   input  wire        sched_in,
   input  wire        beam_in,
   input  wire        supply_on_in,
   input  wire        out_done,
   input  wire [EW-1:0] energy,
   output reg         contactor,
   output reg         emit,
   output reg         out_ready,
   output reg         end_pulse,
   output reg         judge_high,
   output reg         judge_low,
   output reg         irq
);
   localparam ST_OFF   = 3'd0;
   localparam ST_START = 3'd1;
   localparam ST_PREP  = 3'd2;
   localparam ST_READY = 3'd3;
   localparam ST_EMIT  = 3'd4;
   localparam ST_HOLD  = 3'd5;

   wire [4:0] sy;
   lios_sync #(.W(5)) u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .ce   (ce),
      .d    ({out_done, supply_on_in, beam_in, sched_in, laser_start}),
      .q    (sy)
   ); // see RULE14
   reg ext_r;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) ext_r <= 1'b0;
      else if (ce) ext_r <= ctrl_select;
   end
   wire s_start = sy[0];
   wire s_sched = sy[1];
   wire s_beam  = sy[2];
   wire s_suppl = sy[3];
   wire s_done  = sy[4];
   reg  s_done_d_r;

   reg [15:0] tdiv_r;
   reg        tick_r;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tdiv_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= 1'b0;
         if (tdiv_r >= TICK_C - 1) begin
            tdiv_r <= 16'h0000;
            tick_r <= 1'b1; // see RULE14
         end else begin
            tdiv_r <= tdiv_r + 16'h0001;
         end
      end
   end

   reg  [7:0]    ctrl_r;
   reg  [4:0]    ist_r;
   reg  [4:0]    ien_r;
   reg  [EW-1:0] limhi_r;
   reg  [EW-1:0] limlo_r;
   reg  [EW-1:0] elat_r;
   reg  [2:0]    st_r;
   reg  [2:0]    st_nxt;
   reg           key_d_r;
   reg           ext_d_r;

   wire ext_mode = ext_r; // see RULE2
   wire supply_cmd = ext_mode ? s_suppl : ctrl_r[`LIOS_C_SUPPLY];
   wire sched_ok   = ext_mode ? s_sched : ctrl_r[`LIOS_C_SCHED];
   wire beam_ok    = ext_mode ? s_beam :
                     (ctrl_r[`LIOS_C_BEAM] & ctrl_r[`LIOS_C_SHUT]); // see RULE13
   wire key_press  = ctrl_r[`LIOS_C_KEY] & ~key_d_r;
   reg  panel_on_r;

   wire want_emit = ext_mode ? s_start : panel_on_r; // see RULE1
   wire done_rise = s_done & ~s_done_d_r;

   wire sup_done;
   wire prep_done;
   wire hold_done;
   wire pulse_done;
   wire pulse_busy;
   localparam PW20_T = `LIOS_MS_TICKS(`LIOS_PULSE20_MS);
   localparam PW30_T = `LIOS_MS_TICKS(`LIOS_PULSE30_MS);
   localparam PW40_T = `LIOS_MS_TICKS(`LIOS_PULSE40_MS);
   reg  [15:0] plen;
   always @* begin
      case (ctrl_r[`LIOS_C_PW_LSB+1:`LIOS_C_PW_LSB])
         2'd1:    plen = PW30_T[15:0];
         2'd2:    plen = PW40_T[15:0];
         default: plen = PW20_T[15:0];
      endcase // see RULE10
   end

   wire enter_start = (st_r == ST_OFF) && supply_cmd;
   // every way into prep restarts the preparation timer
   wire enter_prep  = (st_nxt == ST_PREP) && (st_r != ST_PREP);
   wire enter_hold  = (st_r == ST_EMIT) && done_rise && ctrl_r[`LIOS_C_REPEAT];

   lios_timer #(.W(16)) u_sup (
      .mclk  (mclk),
      .rstn  (rstn),
      .ce    (ce),
      .tick  (tick_r),
      .start (enter_start),
      .stop  (~supply_cmd),
      .len   (SUPPLY_T[15:0]),
      .busy  (),
      .done  (sup_done)
   ); // see RULE5
   lios_timer #(.W(16)) u_prep (
      .mclk  (mclk),
      .rstn  (rstn),
      .ce    (ce),
      .tick  (tick_r),
      .start (enter_prep),
      .stop  (~supply_cmd),
      .len   (PREP_T[15:0]),
      .busy  (),
      .done  (prep_done)
   ); // see RULE6
   lios_timer #(.W(16)) u_hold (
      .mclk  (mclk),
      .rstn  (rstn),
      .ce    (ce),
      .tick  (tick_r),
      .start (enter_hold),
      .stop  (~supply_cmd),
      .len   (HOLD_T[15:0]),
      .busy  (),
      .done  (hold_done)
   ); // see RULE7
   lios_timer #(.W(16)) u_pulse (
      .mclk  (mclk),
      .rstn  (rstn),
      .ce    (ce),
      .tick  (tick_r),
      .start (done_rise && st_r == ST_EMIT),
      .stop  (1'b0),
      .len   (plen),
      .busy  (pulse_busy),
      .done  (pulse_done)
   );

   reg prep_ok_r;
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_OFF:   if (supply_cmd) st_nxt = ST_START; // see RULE12
         ST_START: if (sup_done) st_nxt = ST_PREP;
         ST_PREP:  if (prep_ok_r && sched_ok) st_nxt = ST_READY; // see RULE8
         ST_READY: if (!sched_ok) st_nxt = ST_PREP;
                   else if (want_emit && beam_ok) st_nxt = ST_EMIT; // see RULE4
         ST_EMIT:  if (done_rise)
                      st_nxt = ctrl_r[`LIOS_C_REPEAT] ? ST_HOLD : ST_READY;
                   else if (!want_emit || !beam_ok) st_nxt = ST_READY;
         ST_HOLD:  if (hold_done) st_nxt = ST_PREP;
         default:  st_nxt = ST_OFF;
      endcase
      if (!supply_cmd) st_nxt = ST_OFF;
   end

   wire ready_ev = (st_nxt == ST_READY) && (st_r != ST_READY);
   wire hi_ev = done_rise && st_r == ST_EMIT && (energy > limhi_r);
   wire lo_ev = done_rise && st_r == ST_EMIT && (energy < limlo_r);
   wire [4:0] ev = {ext_mode ^ ext_d_r, lo_ev, hi_ev, done_rise && st_r == ST_EMIT, ready_ev};

   wire acc = haddr_sel && htrans[1] && hready;
   reg        wr_p_r;
   reg [7:0]  wa_r;
   wire       wr_ctrl = wr_p_r && wa_r == `LIOS_A_CTRL;
   wire       wr_clr  = wr_p_r && wa_r == `LIOS_A_IRQ_CLR;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r       <= ST_OFF;
         key_d_r    <= 1'b0;
         ext_d_r    <= 1'b0;
         s_done_d_r <= 1'b0;
         panel_on_r <= 1'b0;
         prep_ok_r  <= 1'b0;
         elat_r     <= {EW{1'b0}};
         contactor  <= 1'b0;
         emit       <= 1'b0;
         out_ready  <= 1'b0;
         end_pulse  <= 1'b0;
         judge_high <= 1'b0;
         judge_low  <= 1'b0;
         irq        <= 1'b0;
         ist_r      <= 5'h00;
      end else if (ce) begin
         st_r       <= st_nxt;
         key_d_r    <= ctrl_r[`LIOS_C_KEY];
         ext_d_r    <= ext_mode;
         s_done_d_r <= s_done;
         if (st_nxt == ST_PREP && st_r != ST_PREP) prep_ok_r <= 1'b0;
         else if (prep_done) prep_ok_r <= 1'b1;
         if (ext_mode || st_nxt == ST_OFF || done_rise) panel_on_r <= 1'b0;
         else if (key_press) panel_on_r <= ~panel_on_r; // see RULE3
         contactor <= (st_nxt != ST_OFF); // see RULE12
         emit      <= (st_nxt == ST_EMIT);
         out_ready <= (st_nxt == ST_READY); // see RULE7
         if (done_rise && st_r == ST_EMIT) begin
            elat_r     <= energy;
            end_pulse  <= 1'b1; // see RULE10
            judge_high <= (energy > limhi_r); // see RULE11
            judge_low  <= (energy < limlo_r); // see RULE11
         end else if (pulse_done) begin
            end_pulse  <= 1'b0;
            judge_high <= 1'b0;
            judge_low  <= 1'b0;
         end
         ist_r <= (ist_r & ~(wr_clr ? hwdata[4:0] : 5'h00)) | ev;
         irq   <= |(((ist_r & ~(wr_clr ? hwdata[4:0] : 5'h00)) | ev) & ien_r);
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_p_r    <= 1'b0;
         wa_r      <= 8'h00;
         ctrl_r    <= `LIOS_CTRL_RST;
         ien_r     <= 5'h00;
         limhi_r   <= {EW{1'b1}};
         limlo_r   <= {EW{1'b0}};
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         wr_p_r <= acc && hwrite;
         if (acc) wa_r <= haddr[7:0];
         if (wr_ctrl) ctrl_r <= hwdata[7:0];
         if (wr_p_r && wa_r == `LIOS_A_IRQ_EN) ien_r <= hwdata[4:0];
         if (wr_p_r && wa_r == `LIOS_A_LIMHI) limhi_r <= hwdata[EW-1:0];
         if (wr_p_r && wa_r == `LIOS_A_LIMLO) limlo_r <= hwdata[EW-1:0];
         if (acc && !hwrite) begin
            case (haddr[7:0])
               `LIOS_A_CTRL:     hrdata <= {24'h000000, ctrl_r};
               `LIOS_A_STATUS:   hrdata <= {23'h000000, ext_mode, pulse_busy, judge_low,
                                            judge_high, emit, out_ready, st_r};
               `LIOS_A_IRQ_STAT: hrdata <= {27'h0000000, ist_r};
               `LIOS_A_IRQ_EN:   hrdata <= {27'h0000000, ien_r};
               `LIOS_A_ENERGY:   hrdata <= {{(32-EW){1'b0}}, elat_r};
               `LIOS_A_LIMHI:    hrdata <= {{(32-EW){1'b0}}, limhi_r};
               `LIOS_A_LIMLO:    hrdata <= {{(32-EW){1'b0}}, limlo_r};
               default:          hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // lios_top

/* File: pkg/lios_regs.vh */
// Overview of operation
// RULE1 - with the control-select line open the block follows the front panel controller.
// RULE2 - with the control-select line closed the block obeys the discrete connector inputs.
// RULE3 - in panel mode each start/stop key press toggles emission on and off.
// RULE4 - in external mode emission follows the held laser-start input and stops when it opens.
// RULE5 - diode supply start-up completes within at most 5 s of the supply being commanded on.
// RULE6 - output-ready rises no later than 1 s after output preparation is enabled.
// RULE7 - in repeat mode output-ready is held low for a set interval after each output.
// RULE8 - output-ready stays low until a valid output schedule is selected.
// RULE9 - the controller waits at least 150 ms after branch selection before asserting laser start.
// RULE10 - end-of-output and energy-judgment pulses last 20 ms by default, or 30 or 40 ms.
// RULE11 - after each output the measured energy is judged against upper and lower limits.
// RULE12 - the supply contactor output turns on when start-up begins, without emission.
// RULE13 - in panel mode emission needs both branch selection and shutter-on first.
// RULE14 - all intervals count a fixed internal tick and discrete inputs are synchronised; control-select gets one register stage, not two.
`ifndef LIOS_REGS_VH
`define LIOS_REGS_VH

`define LIOS_CLK_HZ        20000000
`define LIOS_TICK_US       100
`define LIOS_TICK_CYC      ((`LIOS_CLK_HZ / 1000000) * `LIOS_TICK_US)
`define LIOS_SUPPLY_MS     5000
`define LIOS_PREP_MS       1000
`define LIOS_SHUTTER_MS    150
`define LIOS_PULSE20_MS    20
`define LIOS_PULSE30_MS    30
`define LIOS_PULSE40_MS    40
`define LIOS_HOLDOFF_MS    10
`define LIOS_MS_TICKS(ms)  (((ms) * 1000) / `LIOS_TICK_US)

`define LIOS_A_CTRL        32'h0000_0000
`define LIOS_A_STATUS      32'h0000_0004
`define LIOS_A_IRQ_STAT    32'h0000_0008
`define LIOS_A_IRQ_EN      32'h0000_000c
`define LIOS_A_IRQ_CLR     32'h0000_0010
`define LIOS_A_ENERGY      32'h0000_0014
`define LIOS_A_LIMHI       32'h0000_0018
`define LIOS_A_LIMLO       32'h0000_001c

`define LIOS_C_SUPPLY      0
`define LIOS_C_SCHED       1
`define LIOS_C_BEAM        2
`define LIOS_C_SHUT        3
`define LIOS_C_REPEAT      4
`define LIOS_C_PW_LSB      5
`define LIOS_C_KEY         7
`define LIOS_CTRL_RST      8'h00

`define LIOS_I_READY       0
`define LIOS_I_END         1
`define LIOS_I_HIGH        2
`define LIOS_I_LOW         3
`define LIOS_I_MODE        4

`endif

/* File: testbench/lios_checker.sv */
`timescale 1ns/1ps
module lios_checker #(
   parameter SUPPLY_T = 3,
   parameter PREP_T   = 3,
   parameter TICK_C   = 4
) (
   input wire mclk,
   input wire rstn,
   input wire hreadyout,
   input wire hresp,
   input wire ctrl_select,
   input wire laser_start,
   input wire sched_in,
   input wire out_done,
   input wire contactor,
   input wire emit,
   input wire out_ready,
   input wire end_pulse,
   input wire judge_high,
   input wire judge_low
);
   localparam int RDY_MAX = (SUPPLY_T + PREP_T + 2) * TICK_C + 12;
   logic [11:0] w_r;
   wire  [11:0] w_tk = (w_r + 12'(TICK_C / 2)) / 12'(TICK_C);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // cycles the end pulse has been high
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         w_r <= 12'h000;
      else
         w_r <= end_pulse ? w_r + 12'h001 : 12'h000;
   end
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready okay");
   property p_emit_sup;
      emit |-> contactor;
   endproperty
   a_emit_sup: assert property (p_emit_sup) else $error("emit without supply");
   property p_dark;
      $rose(contactor) |-> !emit;
   endproperty
   a_dark: assert property (p_dark) else $error("emit at supply start");
   property p_sched;
      (ctrl_select && !sched_in) [*8] |-> !out_ready;
   endproperty
   a_sched: assert property (p_sched) else $error("ready without schedule");
   property p_ext_stop;
      (ctrl_select && !laser_start) [*6] |-> !emit;
   endproperty
   a_ext_stop: assert property (p_ext_stop) else $error("emit with start open");
   property p_rdy_due;
      $rose(contactor) && ctrl_select && sched_in |-> ##[1:RDY_MAX] out_ready;
   endproperty
   a_rdy_due: assert property (p_rdy_due) else $error("ready late");
   property p_width;
      $fell(end_pulse) |-> w_tk inside {12'h0c8, 12'h12c, 12'h190};
   endproperty
   a_width: assert property (p_width) else $error("end pulse width");
   property p_judge;
      !(judge_high && judge_low);
   endproperty
   a_judge: assert property (p_judge) else $error("high and low both");
   property p_end;
      $rose(out_done) |-> ##[1:12] end_pulse;
   endproperty
   a_end: assert property (p_end) else $error("no end pulse");
   c_pulse: cover property ($fell(end_pulse));
   c_ready: cover property ($rose(out_ready));
   c_panel: cover property ($rose(emit) && !ctrl_select);
endmodule // lios_checker

/* File: testbench/lios_plc.sv */
`timescale 1ns/1ps
module lios_plc #(
   parameter SHUT = 8
) (
   input  wire         mclk,
   output logic        ctrl_select,
   output logic        laser_start,
   output logic        sched_in,
   output logic        beam_in,
   output logic        supply_on_in,
   output logic        out_done,
   output logic [15:0] energy
);
   initial begin
      {ctrl_select, laser_start, sched_in, beam_in, supply_on_in, out_done} = 6'h00;
      energy = 16'h0000;
   end
   task automatic power();
      @(posedge mclk);
      ctrl_select  <= 1'b1;
      supply_on_in <= 1'b1;
      sched_in     <= 1'b1;
   endtask
   task automatic sched(input logic v);
      @(posedge mclk);
      sched_in <= v;
   endtask
   task automatic shot(input logic [15:0] e, input int len);
      @(posedge mclk);
      beam_in <= 1'b1;
      repeat (SHUT) @(posedge mclk);
      laser_start <= 1'b1;
      repeat (len) @(posedge mclk);
      laser_start <= 1'b0;
      out_done    <= 1'b1;
      energy      <= e;
      repeat (4) @(posedge mclk);
      out_done <= 1'b0;
      energy   <= ~e;
   endtask
endmodule // lios_plc

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   localparam int T = 4;
   logic        mclk;
   logic        rstn;
   logic        ce;
   logic        haddr_sel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] seen;
   logic [31:0] e32;
   logic [31:0] q[$];
   logic [1:0]  pj;
   int          pw_n;
   int          n;
   int          p;
   int          miscompares;
   int          tests_run;
   event        got;
   logic [31:0] ra[5] = '{32'h0, 32'h4, 32'h8, 32'h18, 32'h40};
   logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'h0};
   logic [7:0]  pk[7] = '{8'h03, 8'h0f, 8'h8f, 8'h0f, 8'h8f, 8'h0b, 8'h8b};
   logic        pe[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   wire  [31:0] hrdata;
   wire  [15:0] energy;
   wire         hreadyout, hresp, ctrl_select, laser_start, sched_in, beam_in;
   wire         supply_on_in, out_done, contactor, emit, out_ready, end_pulse;
   wire         judge_high, judge_low, irq;
   lios_top #(.SUPPLY_T(3), .PREP_T(3), .HOLD_T(2), .TICK_C(T)) dut (
      .ce(ce), .hready(hreadyout), .*);
   lios_plc plc (.*);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatched %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      haddr_sel <= 1'b1;
      htrans    <= 2'h2;
      haddr     <= a;
      hwrite    <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      seen = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
      -> got;
   endtask
   initial forever begin
      @(got);
      chk(seen, q.pop_front());
   end
   // width in ticks and judgement of each end pulse
   always @(posedge mclk) begin
      if (end_pulse === 1'b1) begin
         pw_n <= pw_n + 1;
         pj   <= {judge_high, judge_low};
      end else if (pw_n != 0) begin
         chk({pj, 14'h0, 16'((pw_n + T / 2) / T)}, q.pop_front());
         pw_n <= 0;
      end
   end
   initial begin
      #(20000 * 50);
      miscompares++;
      finish_test();
   end
   initial begin
      n = $urandom(32'h1171);
      rstn = 1'b0;
      {haddr_sel, hwrite, htrans, haddr, hwdata} = 68'h0;
      hsize = 3'h2;
      ce = 1'b1;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      bus(1'b1, 32'h4, 32'hffff_ffff);
      rd(32'h4, 32'h0);
      ce <= 1'b0;
      bus(1'b1, 32'h0, 32'h03);
      ce <= 1'b1;
      rd(32'h0, 32'h0);
      $display("test registers done");
      bus(1'b1, 32'h0, 32'h03);
      for (n = 0; n < 400 && out_ready !== 1'b1; n++) @(posedge mclk);
      chk(contactor, 1'b1);
      chk(out_ready, 1'b1);
      foreach (pk[i]) begin
         bus(1'b1, 32'h0, {24'h0, pk[i]});
         repeat (8) @(posedge mclk);
         chk(emit, pe[i]);
      end
      $display("test panel done");
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'h18, 32'h8000);
      bus(1'b1, 32'h1c, 32'h1000);
      plc.power();
      for (p = 0; p < 3; p++) begin
         bus(1'b1, 32'hc, {30'h0, p != 2, 1'b0});
         bus(1'b1, 32'h0, {p[26:0], p != 2, 4'h0});
         for (n = 0; n < 400 && out_ready !== 1'b1; n++) @(posedge mclk);
         chk(out_ready, 1'b1);
         e32 = p == 0 ? 32'h8001 + $urandom % 32'h7ffe : p == 1 ? $urandom % 32'h1000
                                                              : 32'h1000 + $urandom % 32'h7001;
         q.push_back({p == 0, p == 1, 14'h0, 16'h00c8 + 16'h0064 * p[15:0]});
         fork
            plc.shot(e32[15:0], 20);
            begin
               repeat (22) @(posedge mclk);
               chk(emit, 1'b1);
            end
         join
         repeat (3) @(posedge mclk);
         chk(out_ready, p == 2);
         for (n = 0; n < 20 && end_pulse !== 1'b1; n++) @(posedge mclk);
         for (n = 0; n < 2000 && end_pulse !== 1'b0; n++) @(posedge mclk);
         repeat (2) @(posedge mclk);
         rd(32'h14, e32);
         chk(irq, p != 2);
         bus(1'b1, 32'h10, 32'h1f);
         repeat (2) @(posedge mclk);
         chk(irq, 1'b0);
         $display("test external shot %0d done", p);
      end
      plc.sched(1'b0);
      repeat (10) @(posedge mclk);
      chk(out_ready, 1'b0);
      plc.sched(1'b1);
      for (n = 0; n < 400 && out_ready !== 1'b1; n++) @(posedge mclk);
      chk(out_ready, 1'b1);
      $display("test schedule done");
      finish_test();
   end
endmodule // testbench
bind lios_top lios_checker #(.SUPPLY_T(SUPPLY_T), .PREP_T(PREP_T), .TICK_C(TICK_C))
   chk_i (.*);
